// ### common/gpo_clk_params.svh
`ifndef GPO_CLK_PARAMS_SVH
`define GPO_CLK_PARAMS_SVH

// Select field and pin count.
`define GPO_SEL_W         6
`define GPO_PIN_COUNT     3

// Select codes handled by this block.
`define GPO_CODE_HIZ      6'h2E
`define GPO_CODE_LEVEL    6'h2F
`define GPO_CODE_CLK_BASE 6'h30

// Reset values of the select fields and the invert bit.
`define GPO_RESET_SEL_PIN0 6'h3F
`define GPO_RESET_SEL_PINX 6'h2E
`define GPO_RESET_INV      1'b0

// Divider period width and divisors, in crystal clock cycles.
`define GPO_DIV_W         8
`define GPO_DIV_MIN       8'h02
`define GPO_DIV_3         8'h03
`define GPO_DIV_4         8'h04
`define GPO_DIV_6         8'h06
`define GPO_DIV_8         8'h08
`define GPO_DIV_12        8'h0C
`define GPO_DIV_16        8'h10
`define GPO_DIV_24        8'h18
`define GPO_DIV_32        8'h20
`define GPO_DIV_48        8'h30
`define GPO_DIV_64        8'h40
`define GPO_DIV_96        8'h60
`define GPO_DIV_128       8'h80
`define GPO_DIV_192       8'hC0

`endif

// ### common/gpo_clk_pkg.sv
package gpo_clk_pkg;

  // Per-pin configuration as written by the rest of the selector.
  typedef struct packed {
    logic [5:0] sel;
    logic       inv;
  } pin_cfg_t;

  // Per-pin drive towards the pad.
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  // What a select code asks of a pin.
  typedef enum logic [1:0] {
    MODE_LOWER,
    MODE_HIZ,
    MODE_LEVEL,
    MODE_CLOCK
  } pin_mode_t;

endpackage

// ### dv/gpo_clock_divider_select_bench.sv
`timescale 1ns/100ps

module gpo_clock_divider_select_bench;
  logic                          core_clk;
  logic                          rst;
  logic [2:0]                    cfg_we;
  gpo_clk_pkg::pin_cfg_t         cfg_wdata;
  gpo_clk_pkg::pin_drive_t [2:0] lower_drive;
  gpo_clk_pkg::pin_cfg_t [2:0]   pin_cfg;
  logic [2:0]                    pin_o;
  logic [2:0]                    pin_oe;
  logic [2:0]                    clock_owner;
  logic                          clock_conflict;
  int                            period;
  int                            error_cnt = 0;
  int                            n_checks = 0;

  gpo_clock_divider_select gpo_clock_divider_select_i (.core_clk(core_clk), .rst(rst), .cfg_we(cfg_we),
    .cfg_wdata(cfg_wdata), .lower_drive(lower_drive), .pin_cfg(pin_cfg), .general_output_pin_o(pin_o),
    .general_output_pin_oe(pin_oe), .clock_owner(clock_owner), .clock_conflict(clock_conflict));
  gpo_pad_monitor gpo_pad_monitor_i (.core_clk(core_clk), .pin(pin_o[0]), .period(period));

  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [2:0] we, input logic [6:0] d);
    @(negedge core_clk);
    cfg_we = we;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_we = 3'h0;
  endtask

  task automatic t_reset;
    chk({1'b0, pin_cfg[0]}, 8'h7E);
    chk({1'b0, pin_cfg[1]}, 8'h5C);
    chk({5'h00, pin_oe}, 8'h01);
    settle(600);
    chk(period[7:0], 8'hC0);
  endtask

  task automatic t_level;
    wr(3'h2, 7'h5F);
    settle(3);
    chk({6'h00, pin_oe[1], pin_o[1]}, 8'h03);
    wr(3'h2, 7'h5E);
    settle(3);
    chk({6'h00, pin_oe[1], pin_o[1]}, 8'h02);
    wr(3'h2, 7'h5C);
    settle(3);
    chk({6'h00, pin_oe[1], pin_o[1]}, 8'h00);
  endtask

  task automatic t_lower;
    lower_drive[2] = 2'b11;
    wr(3'h4, 7'h0A);
    settle(3);
    chk({6'h00, pin_oe[2], pin_o[2]}, 8'h03);
    lower_drive[2] = 2'b10;
    settle(2);
    chk({6'h00, pin_oe[2], pin_o[2]}, 8'h01);
  endtask

  task automatic t_divisors;
    logic [7:0] div [13];
    div = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80};
    for (int i = 0; i < 13; i++) begin
      wr(3'h1, {6'(6'h32 + i), 1'b0});
      settle(3 * div[i] + 10);
      chk(period[7:0], div[i]);
    end
  endtask

  task automatic t_conflict;
    wr(3'h1, 7'h68);
    wr(3'h4, 7'h6D);
    settle(40);
    chk({2'b00, clock_conflict, clock_owner, pin_oe[2], pin_o[2]}, 8'h27);
    chk(period[7:0], 8'h04);
    wr(3'h4, 7'h5C);
    settle(3);
    chk({7'h00, clock_conflict}, 8'h00);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    cfg_we = 3'h0;
    cfg_wdata = 7'h00;
    lower_drive = 6'h00;
    settle(16);
    rst = 1'b0;
    settle(2);
    t_reset();
    t_level();
    t_lower();
    t_divisors();
    t_conflict();
    finish_test();
  end
endmodule

// ### dv/gpo_clock_divider_select_props.sv
`timescale 1ns/100ps

module gpo_clock_divider_select_props #(
  parameter int PINS = 3
) (
  input wire logic                             core_clk,
  input wire logic                             rst,
  input wire gpo_clk_pkg::pin_drive_t [PINS-1:0] lower_drive,
  input wire gpo_clk_pkg::pin_cfg_t [PINS-1:0] pin_cfg,
  input wire logic [PINS-1:0]                  general_output_pin_o,
  input wire logic [PINS-1:0]                  general_output_pin_oe,
  input wire logic [PINS-1:0]                  clock_owner,
  input wire logic                             clock_conflict
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_level_follows_inv: assert property ($past(pin_cfg[1].sel) == 6'h2F |->
    general_output_pin_oe[1] && general_output_pin_o[1] == $past(pin_cfg[1].inv)) else $error("level pin wrong");
  a_hiz_released: assert property ($past(pin_cfg[2].sel) == 6'h2E |-> !general_output_pin_oe[2])
    else $error("hi-z pin driven");
  a_lower_pass: assert property ($past(pin_cfg[2].sel) < 6'h2E |->
    general_output_pin_oe[2] == $past(lower_drive[2].oe) &&
    general_output_pin_o[2] == $past(lower_drive[2].out)) else $error("lower drive not passed");
  a_owner_single: assert property ($onehot0(clock_owner)) else $error("several clock owners");
  a_owner_lowest: assert property (!$past(rst) && $past(pin_cfg[0].sel[5:4]) == 2'b11 |-> clock_owner == 3'b001)
    else $error("pin 0 not owner");
  a_conflict_flag: assert property ((pin_cfg[0].sel[5:4] == 2'b11 && pin_cfg[2].sel[5:4] == 2'b11)[*2]
    |-> clock_conflict) else $error("conflict not flagged");
  a_loser_rests: assert property (!$past(rst) && $past(pin_cfg[2].sel[5:4]) == 2'b11 && !clock_owner[2] |->
    general_output_pin_oe[2] && general_output_pin_o[2] == $past(pin_cfg[2].inv)) else $error("losing pin not at level");
  a_reset_default: assert property ($fell(rst) |-> pin_cfg[0] == 7'h7E ##1 clock_owner == 3'b001)
    else $error("pin 0 reset default wrong");
endmodule

bind gpo_clock_divider_select gpo_clock_divider_select_props #(.PINS(PINS)) gpo_clock_divider_select_props_i (
  .core_clk(core_clk), .rst(rst), .lower_drive(lower_drive), .pin_cfg(pin_cfg),
  .general_output_pin_o(general_output_pin_o), .general_output_pin_oe(general_output_pin_oe),
  .clock_owner(clock_owner), .clock_conflict(clock_conflict));

// ### dv/gpo_pad_monitor.sv
`timescale 1ns/100ps

// Measures the cycles between rising edges seen on one pad.
module gpo_pad_monitor (
  // Clock.
  input  wire logic core_clk,
  // Observed pad.
  input  wire logic pin,
  // Last measured period.
  output int        period
);
  logic prev = 1'b0;
  int   cnt  = 0;

  always @(posedge core_clk) begin
    prev <= pin;
    if (pin && !prev) begin
      period <= cnt;
      cnt    <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### hdl/gpo_clock_divider_select.sv
`timescale 1ns/100ps
`include "gpo_clk_params.svh"


module gpo_clock_divider_select #(
  parameter int PINS  = `GPO_PIN_COUNT,
  parameter int DIV_W = `GPO_DIV_W
) (
  // Clock and reset.
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Configuration writes from the selector register file.
  input  wire logic [PINS-1:0]               cfg_we,
  input  wire gpo_clk_pkg::pin_cfg_t         cfg_wdata,
  // Drive from the lower select codes, owned by other logic.
  input  wire gpo_clk_pkg::pin_drive_t [PINS-1:0] lower_drive,
  // Current configuration, for read back.
  output gpo_clk_pkg::pin_cfg_t [PINS-1:0]   pin_cfg,
  // Pads of the general output pins.
  output logic [PINS-1:0]                    general_output_pin_o,
  output logic [PINS-1:0]                    general_output_pin_oe,
  // Status.
  output logic [PINS-1:0]                    clock_owner,
  output logic                               clock_conflict
);

  gpo_clk_pkg::pin_cfg_t [PINS-1:0] next_pin_cfg;
  gpo_clk_pkg::pin_mode_t [PINS-1:0] pin_mode;
  gpo_clk_pkg::pin_drive_t [PINS-1:0] next_drive;
  logic [PINS-1:0]                   next_out;
  logic [PINS-1:0]                   next_oe;
  logic [PINS-1:0]                   next_owner;
  logic [PINS-1:0]                   clock_request;
  logic                              next_conflict;
  logic                              owner_found;
  logic [5:0]                        owner_sel;
  logic [DIV_W-1:0]                  div_period;
  logic                              div_enable;
  logic                              crystal_clock_divided;

  // Maps a select code to what the pin must do.
  function automatic gpo_clk_pkg::pin_mode_t decode_mode(input logic [5:0] sel);
    if (sel >= `GPO_CODE_CLK_BASE) begin
      decode_mode = gpo_clk_pkg::MODE_CLOCK;
    end else if (sel == `GPO_CODE_LEVEL) begin
      decode_mode = gpo_clk_pkg::MODE_LEVEL;
    end else if (sel == `GPO_CODE_HIZ) begin
      decode_mode = gpo_clk_pkg::MODE_HIZ;
    end else begin
      decode_mode = gpo_clk_pkg::MODE_LOWER;
    end
  endfunction

  // Maps a clock select code to its divisor. A registered divider cannot make /1 or /1.5,
  // so those codes are held at /2 rather than left undefined.
  function automatic logic [DIV_W-1:0] divisor_of(input logic [5:0] sel);
    logic [DIV_W-1:0] d;
    d = `GPO_DIV_MIN;
    unique case (sel[3:0])
      4'h0, 4'h1, 4'h2: d = `GPO_DIV_MIN;
      4'h3: d = `GPO_DIV_3;
      4'h4: d = `GPO_DIV_4;
      4'h5: d = `GPO_DIV_6;
      4'h6: d = `GPO_DIV_8;
      4'h7: d = `GPO_DIV_12;
      4'h8: d = `GPO_DIV_16;
      4'h9: d = `GPO_DIV_24;
      4'hA: d = `GPO_DIV_32;
      4'hB: d = `GPO_DIV_48;
      4'hC: d = `GPO_DIV_64;
      4'hD: d = `GPO_DIV_96;
      4'hE: d = `GPO_DIV_128;
      4'hF: d = `GPO_DIV_192;
    endcase
    divisor_of = d;
  endfunction

  // Tells whether more than one bit of a pin mask is set.
  function automatic logic several_set(input logic [PINS-1:0] mask);
    int ones;
    ones = 0;
    for (int i = 0; i < PINS; i++) begin
      if (mask[i]) begin
        ones++;
      end
    end
    several_set = (ones > 1);
  endfunction

  // Gives the pad drive of one pin. A clock pin that lost the shared divider keeps driving
  // its invert level, so a broken one-clock rule shows as a steady pin, not a second clock.
  function automatic gpo_clk_pkg::pin_drive_t pad_drive(
    input gpo_clk_pkg::pin_mode_t  mode,
    input logic                    inv,
    input gpo_clk_pkg::pin_drive_t lower,
    input logic                    clk_bit
  );
    gpo_clk_pkg::pin_drive_t d;
    d = '0;
    unique case (mode)
      gpo_clk_pkg::MODE_LOWER: begin
        d = lower;
      end
      gpo_clk_pkg::MODE_HIZ: begin
        d.out = 1'b0;
        d.oe  = 1'b0;
      end
      gpo_clk_pkg::MODE_LEVEL: begin
        d.out = inv;
        d.oe  = 1'b1;
      end
      gpo_clk_pkg::MODE_CLOCK: begin
        d.out = clk_bit ^ inv;
        d.oe  = 1'b1;
      end
    endcase
    pad_drive = d;
  endfunction

  // Configuration registers. A write to several pins at once gives them all the same code;
  // the conflict flag then shows it when that code is a clock code.
  always_comb begin
    next_pin_cfg = pin_cfg;
    for (int i = 0; i < PINS; i++) begin
      if (cfg_we[i]) begin
        next_pin_cfg[i] = cfg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PINS; i++) begin
        if (i == 0) begin
          pin_cfg[i].sel <= `GPO_RESET_SEL_PIN0;
        end else begin
          pin_cfg[i].sel <= `GPO_RESET_SEL_PINX;
        end
        pin_cfg[i].inv <= `GPO_RESET_INV;
      end
    end else begin
      pin_cfg <= next_pin_cfg;
    end
  end

  // Decodes what each pin's select code asks for. Every one of the 64 codes lands in
  // one of four modes, so no code leaves a pin undefined.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_mode[i]      = decode_mode(pin_cfg[i].sel);
      clock_request[i] = (pin_mode[i] == gpo_clk_pkg::MODE_CLOCK);
    end
  end

  // Picks the one pin that owns the shared divider; the lowest index wins,
  // so pin 0's reset clock survives while the other pins are set up.
  always_comb begin
    owner_found = 1'b0;
    owner_sel   = `GPO_CODE_CLK_BASE;
    next_owner  = '0;
    for (int i = 0; i < PINS; i++) begin
      if (clock_request[i] && !owner_found) begin
        owner_found   = 1'b1;
        owner_sel     = pin_cfg[i].sel;
        next_owner[i] = 1'b1;
      end
    end
  end

  // Flags a second clock request; only the owner gets the divider.
  always_comb begin
    next_conflict = several_set(clock_request);
  end

  // Feeds the shared divider from the owner's code.
  always_comb begin
    div_enable = owner_found;
    div_period = divisor_of(owner_sel);
  end

  xtal_clock_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .core_clk (core_clk),
    .rst      (rst),
    .enable   (div_enable),
    .period   (div_period),
    .clk_div  (crystal_clock_divided)
  );

  // Pad drive for each pin.
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      next_drive[i] = pad_drive(pin_mode[i], pin_cfg[i].inv, lower_drive[i],
                                next_owner[i] & crystal_clock_divided);
      next_out[i]   = next_drive[i].out;
      next_oe[i]    = next_drive[i].oe;
    end
  end

  // Every pad signal leaves through a flip-flop, so a code change never glitches a pin.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      general_output_pin_o  <= '0;
      general_output_pin_oe <= '0;
      clock_owner           <= '0;
      clock_conflict        <= 1'b0;
    end else begin
      general_output_pin_o  <= next_out;
      general_output_pin_oe <= next_oe;
      clock_owner           <= next_owner;
      clock_conflict        <= next_conflict;
    end
  end

endmodule

// ### hdl/xtal_clock_divider.sv
`timescale 1ns/100ps
`include "gpo_clk_params.svh"

module xtal_clock_divider #(
  parameter int DIV_W = `GPO_DIV_W
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             enable,
  input  wire logic [DIV_W-1:0] period,
  // Divided clock.
  output logic                  clk_div
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [DIV_W-1:0] last_period;
  logic             next_clk_div;
  logic [DIV_W-1:0] high_len;

  // The count restarts whenever the period changes, so a new divisor starts with a clean high phase.
  always_comb begin
    high_len = period - (period >> 1);
    if (!enable || period != last_period || count >= period - DIV_W'(1)) begin
      next_count = '0;
    end else begin
      next_count = count + DIV_W'(1);
    end
    next_clk_div = enable && (next_count < high_len);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count       <= '0;
      last_period <= '0;
      clk_div     <= 1'b0;
    end else begin
      count       <= next_count;
      last_period <= period;
      clk_div     <= next_clk_div;
    end
  end

endmodule
